// file: hdl/wdog_ta_regs.vh
`ifndef WDOG_TA_REGS_VH
`define WDOG_TA_REGS_VH

// Register offsets on the core's register port
`define CLK_WD_PERIOD_ADDR 8'h8e
`define UNLOCK_KEY_ADDR    8'hc7
`define WD_PF_CTRL_ADDR    8'hd8
`define EXT_IRQ_EN_ADDR    8'he8
`define EXT_IRQ_FLAG_ADDR  8'h91
`define ROM_SIZE_ADDR      8'hc2

// Field positions
`define PERIOD_SEL_HI      7
`define PERIOD_SEL_LO      6
`define POR_FLAG_BIT       6
`define PF_IRQ_EN_BIT      5
`define PF_FLAG_BIT        4
`define WD_IRQ_FLAG_BIT    3
`define WD_RST_FLAG_BIT    2
`define WD_RST_EN_BIT      1
`define WD_RESTART_BIT     0
`define WD_IRQ_EN_BIT      4
`define BANDGAP_BIT        0

// Reset values
`define CLK_WD_PERIOD_RST  8'h00
`define EXT_IRQ_EN_RST     8'h00
`define ROM_SIZE_RST       3'h0

// Unlock sequence and window
`define UNLOCK_KEY_FIRST   8'haa
`define UNLOCK_KEY_SECOND  8'h55
`define UNLOCK_WINDOW      2'h3

// Timing counts in crystal clocks
`define WD_RESET_EXTRA     27'h0000200

// Interrupt vectors and natural priorities
`define SUPPLY_WARN_VECTOR 16'h0033
`define WD_TIMEOUT_VECTOR  16'h0063
`define SUPPLY_WARN_PRIO   4'h1
`define WD_TIMEOUT_PRIO    4'hd

`endif

// file: hdl/watchdog_timed_access.v
// Behaviour
// - Enabled supply warning makes the core vector to 0033h.
// - Control bit 5 arms the supply warning interrupt.
// - Supply warning sets control bit 4 always; stays until software clears.
// - Watchdog counter runs on every clock, needing no enable.
// - Period bits 7:6 pick 2^17, 2^20, 2^23 or 2^26 clocks.
// - After the interrupt count, 512 more clocks then the reset flag.
// - Interrupt flag bit 3 sets at interrupt count end.
// - Reset flag bit 2 sets on full expiry and is kept.
// - Bit 1 enables reset; full expiry then resets the CPU.
// - Writing one to bit 0 restarts the counter.
// - Enable bit 4 arms the timeout interrupt; vector 63h, priority 13.
// - Timeout interrupt wakes the core, independent of reset enable.
// - Supply warning interrupt outranks every other source.
// - Keys AAh then 55h at C7h open a three-cycle window.
// - Protected writes outside the window leave the bits unchanged.
// - Protection covers reset enable, restart, POR and watchdog interrupt flags, band-gap, ROM size.
// - Flag register bit 0 keeps band-gap on in stop; resets zero.
`include "wdog_ta_regs.vh"
`default_nettype none

module watchdog_timed_access #(
    parameter [26:0] TMO_SEL0 = 27'd131072,
    parameter [26:0] TMO_SEL1 = 27'd1048576,
    parameter [26:0] TMO_SEL2 = 27'd8388608,
    parameter [26:0] TMO_SEL3 = 27'd67108864
) (
    input  wire        CORE_CLK_I,
    input  wire        SYS_RST_I,
    input  wire [7:0]  SFR_ADDR_I,
    input  wire [7:0]  SFR_WDATA_I,
    input  wire        SFR_WR_I,
    input  wire        SFR_RD_I,
    input  wire        SUPPLY_LOW_I,
    output reg  [7:0]  SFR_RDATA_O,
    output wire        SUPPLY_WARNING_IRQ_O,
    output wire        WATCHDOG_TIMEOUT_IRQ_O,
    output wire        IRQ_REQ_O,
    output wire [15:0] IRQ_VECTOR_O,
    output wire [3:0]  IRQ_PRIO_O,
    output wire        WAKE_O,
    output reg         CPU_RESET_O,
    output wire        BANDGAP_KEEP_ON_O,
    output wire [2:0]  ROM_SIZE_O
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_KEY1 = 3'b010;
    localparam [2:0] ST_OPEN = 3'b100;

    reg [7:0]  period_ctrl_q;
    reg [7:0]  irq_en_q;
    reg        por_flag_q;
    reg        pf_irq_en_q;
    reg        pf_flag_q;
    reg        wd_irq_flag_q;
    reg        wd_rst_flag_q;
    reg        wd_rst_en_q;
    reg        bandgap_q;
    reg [2:0]  rom_size_q;
    reg [26:0] wd_cnt_q;
    reg [2:0]  ta_state_q;
    reg [2:0]  ta_state_d;
    reg [1:0]  ta_cnt_q;
    reg [1:0]  ta_cnt_d;

    function [26:0] tmo_len;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   tmo_len = TMO_SEL0;
                2'b01:   tmo_len = TMO_SEL1;
                2'b10:   tmo_len = TMO_SEL2;
                default: tmo_len = TMO_SEL3;
            endcase
        end
    endfunction

    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = SFR_WR_I && (SFR_ADDR_I == addr);
        end
    endfunction

    wire        ctrl_wr    = wr_hit(`WD_PF_CTRL_ADDR);
    wire        flag_wr    = wr_hit(`EXT_IRQ_FLAG_ADDR);
    wire        rom_wr     = wr_hit(`ROM_SIZE_ADDR);
    wire        key_wr     = wr_hit(`UNLOCK_KEY_ADDR);
    wire        unlocked   = (ta_state_q == ST_OPEN);
    wire        prot_wr    = ctrl_wr | flag_wr | rom_wr;
    wire [26:0] irq_point  = tmo_len(period_ctrl_q[`PERIOD_SEL_HI:
                                                   `PERIOD_SEL_LO]);
    wire [26:0] rst_point  = irq_point + `WD_RESET_EXTRA;
    wire        irq_hit    = (wd_cnt_q == irq_point);
    wire        expire     = (wd_cnt_q == rst_point);
    wire        restart    = unlocked && ctrl_wr
                             && SFR_WDATA_I[`WD_RESTART_BIT];

    // Unlock sequence; a wrong key falls back to the start
    always @* begin
        ta_state_d = ta_state_q;
        ta_cnt_d   = ta_cnt_q;
        case (ta_state_q)
            ST_IDLE: begin
                if (key_wr && SFR_WDATA_I == `UNLOCK_KEY_FIRST)
                    ta_state_d = ST_KEY1;
            end
            ST_KEY1: begin
                if (key_wr) begin
                    if (SFR_WDATA_I == `UNLOCK_KEY_SECOND) begin
                        ta_state_d = ST_OPEN;
                        ta_cnt_d   = `UNLOCK_WINDOW;
                    end else begin
                        ta_state_d = ST_IDLE;
                    end
                end else if (SFR_WR_I) begin
                    ta_state_d = ST_IDLE;
                end
            end
            ST_OPEN: begin
                if (prot_wr || ta_cnt_q == 2'h1) begin
                    ta_state_d = ST_IDLE;
                    ta_cnt_d   = 2'h0;
                end else begin
                    ta_cnt_d   = ta_cnt_q - 2'h1;
                end
                if (key_wr && SFR_WDATA_I == `UNLOCK_KEY_FIRST)
                    ta_state_d = ST_KEY1;
            end
            default: begin
                ta_state_d = ST_IDLE;
                ta_cnt_d   = 2'h0;
            end
        endcase
    end

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ta_state_q <= ST_IDLE;
            ta_cnt_q   <= 2'h0;
        end else begin
            ta_state_q <= ta_state_d;
            ta_cnt_q   <= ta_cnt_d;
        end
    end

    // Counter never stops; only restart or expiry reloads it
    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wd_cnt_q    <= 27'h0;
            CPU_RESET_O <= 1'b0;
        end else begin
            CPU_RESET_O <= expire && wd_rst_en_q;
            if (restart || expire)
                wd_cnt_q <= 27'h0;
            else
                wd_cnt_q <= wd_cnt_q + 27'h1;
        end
    end

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            period_ctrl_q <= `CLK_WD_PERIOD_RST;
            irq_en_q      <= `EXT_IRQ_EN_RST;
            por_flag_q    <= 1'b1;
            pf_irq_en_q   <= 1'b0;
            pf_flag_q     <= 1'b0;
            wd_irq_flag_q <= 1'b0;
            wd_rst_flag_q <= 1'b0;
            wd_rst_en_q   <= 1'b0;
            bandgap_q     <= 1'b0;
            rom_size_q    <= `ROM_SIZE_RST;
        end else begin
            if (wr_hit(`CLK_WD_PERIOD_ADDR))
                period_ctrl_q <= SFR_WDATA_I;
            if (wr_hit(`EXT_IRQ_EN_ADDR))
                irq_en_q <= SFR_WDATA_I;
            if (ctrl_wr) begin
                pf_irq_en_q <= SFR_WDATA_I[`PF_IRQ_EN_BIT];
                if (!SFR_WDATA_I[`PF_FLAG_BIT])
                    pf_flag_q <= 1'b0;
                if (!SFR_WDATA_I[`WD_RST_FLAG_BIT])
                    wd_rst_flag_q <= 1'b0;
            end
            // Protected bits move only inside the window
            if (ctrl_wr && unlocked) begin
                por_flag_q    <= SFR_WDATA_I[`POR_FLAG_BIT];
                wd_irq_flag_q <= SFR_WDATA_I[`WD_IRQ_FLAG_BIT];
                wd_rst_en_q   <= SFR_WDATA_I[`WD_RST_EN_BIT];
            end
            if (flag_wr && unlocked)
                bandgap_q <= SFR_WDATA_I[`BANDGAP_BIT];
            if (rom_wr && unlocked)
                rom_size_q <= SFR_WDATA_I[2:0];
            // Hardware sets last so an event beats a clear
            if (SUPPLY_LOW_I)
                pf_flag_q <= 1'b1;
            if (irq_hit)
                wd_irq_flag_q <= 1'b1;
            if (expire)
                wd_rst_flag_q <= 1'b1;
        end
    end

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SFR_RDATA_O <= 8'h00;
        end else if (SFR_RD_I) begin
            case (SFR_ADDR_I)
                `CLK_WD_PERIOD_ADDR: SFR_RDATA_O <= period_ctrl_q;
                `EXT_IRQ_EN_ADDR:    SFR_RDATA_O <= irq_en_q;
                `WD_PF_CTRL_ADDR:    SFR_RDATA_O <= {1'b0, por_flag_q,
                                                     pf_irq_en_q, pf_flag_q,
                                                     wd_irq_flag_q,
                                                     wd_rst_flag_q,
                                                     wd_rst_en_q, 1'b0};
                `EXT_IRQ_FLAG_ADDR:  SFR_RDATA_O <= {7'h00, bandgap_q};
                `ROM_SIZE_ADDR:      SFR_RDATA_O <= {5'h00, rom_size_q};
                default:             SFR_RDATA_O <= 8'h00;
            endcase
        end
    end

    assign SUPPLY_WARNING_IRQ_O   = pf_irq_en_q && pf_flag_q;
    assign WATCHDOG_TIMEOUT_IRQ_O = irq_en_q[`WD_IRQ_EN_BIT]
                                    && wd_irq_flag_q;
    assign IRQ_REQ_O    = SUPPLY_WARNING_IRQ_O | WATCHDOG_TIMEOUT_IRQ_O;
    // Supply warning always wins the vector
    assign IRQ_VECTOR_O = SUPPLY_WARNING_IRQ_O ? `SUPPLY_WARN_VECTOR
                                               : `WD_TIMEOUT_VECTOR;
    assign IRQ_PRIO_O   = SUPPLY_WARNING_IRQ_O ? `SUPPLY_WARN_PRIO
                                               : `WD_TIMEOUT_PRIO;
    // Wake ignores the reset enable on purpose
    assign WAKE_O            = IRQ_REQ_O;
    assign BANDGAP_KEEP_ON_O = bandgap_q;
    assign ROM_SIZE_O        = rom_size_q;

endmodule // watchdog_timed_access

`default_nettype wire

// file: verification/wdog_asserts.sv
`default_nettype none
module wdog_chk (
    input wire logic        CORE_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic [7:0]  SFR_ADDR_I,
    input wire logic [7:0]  SFR_WDATA_I,
    input wire logic        SFR_WR_I,
    input wire logic        SUPPLY_WARNING_IRQ_O,
    input wire logic        WATCHDOG_TIMEOUT_IRQ_O,
    input wire logic        IRQ_REQ_O,
    input wire logic [15:0] IRQ_VECTOR_O,
    input wire logic [3:0]  IRQ_PRIO_O,
    input wire logic        WAKE_O,
    input wire logic        CPU_RESET_O,
    input wire logic        BANDGAP_KEEP_ON_O,
    input wire logic [2:0]  ROM_SIZE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] gap_q;
    logic [2:0] age_q;
    logic       aa_q, wt_q, wrd_q;
    wire        key_wr = SFR_WR_I && SFR_ADDR_I == 8'hc7;
    // Gap only trusted from a hardware rise; writes or CPU reset clear the count
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            {gap_q, age_q, aa_q, wt_q, wrd_q} <= '0;
        end else begin
            wt_q <= WATCHDOG_TIMEOUT_IRQ_O;
            wrd_q <= SFR_WR_I;
            if (SFR_WR_I || CPU_RESET_O)
                gap_q <= '0;
            else if (WATCHDOG_TIMEOUT_IRQ_O && !wt_q && !wrd_q)
                gap_q <= 10'h001;
            else if (gap_q != '0 && gap_q != '1)
                gap_q <= gap_q + 10'h001;
            if (SFR_WR_I) begin
                aa_q <= key_wr && SFR_WDATA_I == 8'haa;
                age_q <= {2'b00, key_wr && SFR_WDATA_I == 8'h55 && aa_q};
            end else if (age_q != '0 && age_q != '1)
                age_q <= age_q + 3'h1;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    AST_PF_VEC: assert property (SUPPLY_WARNING_IRQ_O |->
        IRQ_VECTOR_O == 16'h0033 && IRQ_PRIO_O == 4'h1)
        else $error("supply warning vector wrong");
    AST_WD_VEC: assert property (
        WATCHDOG_TIMEOUT_IRQ_O && !SUPPLY_WARNING_IRQ_O |->
        IRQ_VECTOR_O == 16'h0063 && IRQ_PRIO_O == 4'hd)
        else $error("timeout vector wrong");
    AST_WAKE: assert property (WAKE_O == IRQ_REQ_O &&
        IRQ_REQ_O == (SUPPLY_WARNING_IRQ_O || WATCHDOG_TIMEOUT_IRQ_O))
        else $error("wake or request wrong");
    AST_PF_HOLD: assert property ($fell(SUPPLY_WARNING_IRQ_O) |->
        $past(SFR_WR_I) && $past(SFR_ADDR_I) == 8'hd8)
        else $error("supply flag dropped alone");
    AST_RST_PULSE: assert property (
        CPU_RESET_O |=> !CPU_RESET_O [*8])
        else $error("cpu reset too long");
    AST_RST_GAP: assert property (
        CPU_RESET_O && gap_q != '0 |-> gap_q == 10'd512)
        else $error("reset not 512 after irq");
    AST_PROT: assert property (
        $changed(ROM_SIZE_O) || $changed(BANDGAP_KEEP_ON_O) |->
        $past(age_q) inside {3'h1, 3'h2, 3'h3})
        else $error("protected bit changed unlocked");
    AST_BGS: assert property ($rose(BANDGAP_KEEP_ON_O) |->
        $past(SFR_ADDR_I) == 8'h91 && $past(SFR_WDATA_I[0]))
        else $error("band-gap set without write");
    cover property ($rose(CPU_RESET_O));
    cover property ($rose(SUPPLY_WARNING_IRQ_O));
    cover property ($changed(ROM_SIZE_O));
endmodule // wdog_chk
`default_nettype wire

// file: verification/core_model.sv
`default_nettype none
module core_model (
    input  wire logic       clk_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Entered just after an edge; strobe stays up for back-to-back writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
    endtask
    // Released lines show inverted values so stale data is never trusted
    task automatic idle();
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        idle();
        d = rdata_i;
    endtask
    task automatic guarded(input logic [7:0] a, input logic [7:0] d);
        wr(8'hc7, 8'haa);
        wr(8'hc7, 8'h55);
        wr(a, d);
        idle();
    endtask
endmodule // core_model
`default_nettype wire

// file: verification/watchdog_timed_access_tb_top.sv
`default_nettype none
module watchdog_timed_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] RA = 40'h8ee8d891c2;
    localparam logic [39:0] RV = 40'h0000400000;
    logic        clk, rst, low;
    logic [7:0]  v, r;
    wire  [7:0]  addr, wdata, rdata;
    wire         wr, rd, pf_irq, wd_irq, req, wake, cpu_rst, bandgap_keep_on;
    wire  [15:0] vec;
    wire  [3:0]  prio;
    wire  [2:0]  rom;
    int          bad_count, num_checks, n;
    always #5 clk = ~clk;
    core_model u_core (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    watchdog_timed_access #(.TMO_SEL0(27'd16), .TMO_SEL1(27'd32),
        .TMO_SEL2(27'd64), .TMO_SEL3(27'd128)) u_dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr),
        .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd),
        .SUPPLY_LOW_I(low), .SFR_RDATA_O(rdata),
        .SUPPLY_WARNING_IRQ_O(pf_irq), .WATCHDOG_TIMEOUT_IRQ_O(wd_irq),
        .IRQ_REQ_O(req), .IRQ_VECTOR_O(vec), .IRQ_PRIO_O(prio),
        .WAKE_O(wake), .CPU_RESET_O(cpu_rst), .BANDGAP_KEEP_ON_O(bandgap_keep_on),
        .ROM_SIZE_O(rom));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {clk, rst, low, bad_count, num_checks} = {3'b010, 64'h0};
        v = 8'($urandom(32'hb731));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Read d8 early, before the free-running count sets its flag
        for (int i = 4; i >= 0; i--) begin
            u_core.rd(RA[8*i +: 8], r);
            check(r, RV[8*i +: 8]);
        end
        check(vec, 16'h0063);
        $display("reset values done");
        v = 8'($urandom_range(7, 1));
        u_core.wr(8'hc2, v);
        u_core.wr(8'hc7, 8'haa);
        u_core.wr(8'hc7, 8'h12);
        u_core.wr(8'hc7, 8'h55);
        u_core.wr(8'hc2, v);
        u_core.idle();
        check(rom, 3'h0);
        u_core.wr(8'hc7, 8'haa);
        u_core.wr(8'hc7, 8'h55);
        repeat (3) u_core.idle();
        u_core.wr(8'hc2, v);
        u_core.idle();
        check(rom, 3'h0);
        u_core.wr(8'hc7, 8'haa);
        u_core.wr(8'hc7, 8'h55);
        repeat (2) u_core.idle();
        u_core.wr(8'hc2, v);
        u_core.idle();
        check(rom, v[2:0]);
        u_core.guarded(8'h91, 8'h01);
        u_core.wr(8'hc2, ~v);
        u_core.idle();
        check({bandgap_keep_on, rom}, {1'b1, v[2:0]});
        $display("protection done");
        for (int en = 1; en >= 0; en--) begin
            u_core.wr(8'hd8, en ? 8'h20 : 8'h00);
            low <= 1'b1;
            u_core.idle();
            low <= 1'b0;
            u_core.idle();
            check(pf_irq, en[0]);
            check(vec, en ? 16'h0033 : 16'h0063);
            check(prio, en ? 4'h1 : 4'hd);
            u_core.rd(8'hd8, r);
            check(r[5:3], {en[0], 2'b11});
        end
        $display("supply warning done");
        u_core.wr(8'he8, 8'h10);
        for (int s = 0; s < 4; s++) begin
            u_core.wr(8'h8e, 8'(s << 6));
            u_core.guarded(8'hd8, {6'h00, ~s[0], 1'b1});
            n = 1;
            // Sample after the edge so the flag launched there is seen
            while (!wd_irq && n < 300) begin
                @(posedge clk);
                #1;
                n++;
            end
            check(16'(n), 16'((16 << s) + 1));
            n = 0;
            while (!cpu_rst && n < 600) begin
                @(posedge clk);
                #1;
                n++;
            end
            check(16'(n), s[0] ? 16'd600 : 16'd512);
            u_core.rd(8'hd8, r);
            check(r[3:2], 2'b11);
        end
        $display("watchdog done");
        u_core.wr(8'h8e, 8'h00);
        repeat (4 + $urandom_range(4)) u_core.guarded(8'hd8, 8'h03);
        check(wd_irq, 1'b0);
        $display("restart done");
        wrap_up();
    end
endmodule // watchdog_timed_access_tb_top
bind watchdog_timed_access wdog_chk u_chk (.CORE_CLK_I(CORE_CLK_I),
    .SYS_RST_I(SYS_RST_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .SUPPLY_WARNING_IRQ_O(SUPPLY_WARNING_IRQ_O),
    .WATCHDOG_TIMEOUT_IRQ_O(WATCHDOG_TIMEOUT_IRQ_O), .IRQ_REQ_O(IRQ_REQ_O),
    .IRQ_VECTOR_O(IRQ_VECTOR_O), .IRQ_PRIO_O(IRQ_PRIO_O), .WAKE_O(WAKE_O),
    .CPU_RESET_O(CPU_RESET_O), .BANDGAP_KEEP_ON_O(BANDGAP_KEEP_ON_O),
    .ROM_SIZE_O(ROM_SIZE_O));
`default_nettype wire
